// *** fpss_pkg.sv ***
// Package: constants for the flash program/suspend host controller
package fpss_pkg;
	localparam int CLK_HZ = 40000000;
	// Bus strobe timing, in ns
	localparam int STROBE_NS = 100;
	localparam int STROBE_CYC = (STROBE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
	// Erase suspend latency, in us
	localparam int SUSP_US = 20;
	localparam int SUSP_CYC = SUSP_US * (CLK_HZ / 1000000);
	// APB register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0c;
	localparam logic [7:0] REG_RDAT = 8'h10;
	// Command codes in CTRL[2:0]
	localparam logic [2:0] OP_READ = 3'h1;
	localparam logic [2:0] OP_PROG = 3'h2;
	localparam logic [2:0] OP_SUSP = 3'h3;
	localparam logic [2:0] OP_RESUME = 3'h4;
	localparam logic [2:0] OP_RESET = 3'h5;
	// Flash command bytes and unlock addresses
	localparam logic [15:0] UNL_ADDR1 = 16'h0555;
	localparam logic [15:0] UNL_ADDR2 = 16'h02aa;
	localparam logic [15:0] UNL_DATA1 = 16'h00aa;
	localparam logic [15:0] UNL_DATA2 = 16'h0055;
	localparam logic [15:0] CMD_PROG = 16'h00a0;
	localparam logic [15:0] CMD_SUSP = 16'h00b0;
	localparam logic [15:0] CMD_RESUME = 16'h0030;
	localparam logic [15:0] CMD_RESET = 16'h00f0;
	// Status bit positions on the data bus
	localparam int BIT_POLL = 7;
	localparam int BIT_TOG1 = 6;
	localparam int BIT_TOUT = 5;
	// STAT register bits
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_RYBY = 3;
	localparam logic [2:0] SEQ_PROG_LEN = 3'h4;
	typedef enum logic [3:0] {
		FS_IDLE = 4'b0000,
		FS_WSET = 4'b0001,
		FS_WLOW = 4'b0010,
		FS_WHI = 4'b0011,
		FS_RSET = 4'b0100,
		FS_RLOW = 4'b0101,
		FS_RHI = 4'b0110,
		FS_NEXT = 4'b0111
	} fpss_state_t;
endpackage : fpss_pkg

// *** fpss_host.sv ***
// Host controller: drives flash strobes for program, suspend, resume and status polling
//
// How it works
// R01: Suspend only meaningful during sector erase
// R02: Device halts erase within 20 us
// R03: Suspend in load window suspends at once
// R04: Suspended device accepts read, resume, program
// R05: Resume acts only after a suspend
// R06: Host may suspend again after resume
// R07: Program: two unlocks, A0H, address/data
// R08: Address on falling, data on rising strobe
// R09: One word per program; device self-times
// R10: Commands during programming are ignored
// R11: Reset aborts; host reissues program sequence (the controller only issues the reset, then idles with fail set)
// R12: Programming never turns 0 into 1
// R13: Device returns to read after program
// R14: Timeout flag set on pulse overrun
// R15: Done when toggle stable, bits match data
// R16: Poll bit is complement until done
// R17: Protected address: brief poll, no program
// R18: Erase poll reads 0, then 1
// R19: All protected: brief poll, then read
// R20: Reread after poll bit turns true
// R21: Ready/busy is open drain, shared line
// R22: Ready/busy low while busy
// R23: Toggle one inverts each read while busy
// R24: Toggle two inverts in erase sectors
// R25: Device state machine shows status bits
//
// The register addresses and the APB register port were chosen for this implementation.
module fpss_host
	import fpss_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [18:0] flashAddr,
	output logic [15:0] flashDout,
	output logic flashDoe,
	input wire logic [15:0] flashDin,
	output logic chipEn_b,
	output logic writeEn_b,
	output logic outEn_b,
	input wire logic ready_busy_n
);
	////////////////////////////////////////////////////////////////////////
	fpss_state_t state;
	logic [15:0] dinS1, dinS2;
	logic rybyS1, rybyS2;
	logic [18:0] progAddr;
	logic [15:0] progData;
	logic [2:0] op;
	logic [2:0] step;
	logic [3:0] tmr;
	logic busy, done, fail;
	logic polling;
	logic [15:0] lastRead;
	logic haveLast;
	logic [15:0] rdData;
	logic apbWr, apbRd;

	assign apbWr = psel && penable && pwrite;
	assign apbRd = psel && !penable && !pwrite;

	// Cycle n of a command sequence: address and data to drive
	function automatic logic [34:0] seqWord(input logic [2:0] o, input logic [2:0] s,
		input logic [18:0] a, input logic [15:0] d);
		logic [34:0] w;
		w = {3'h0, 16'h0000, d};
		case (o)
			OP_PROG:
				case (s)
					3'h0: w = {3'h0, UNL_ADDR1, UNL_DATA1};
					3'h1: w = {3'h0, UNL_ADDR2, UNL_DATA2};
					3'h2: w = {3'h0, UNL_ADDR1, CMD_PROG};
					default: w = {a, d}; // [R07] [R09]
				endcase
			OP_SUSP: w = {a, CMD_SUSP}; // [R01] [R06]
			OP_RESUME: w = {a, CMD_RESUME}; // [R05]
			default: w = {a, CMD_RESET};
		endcase
		return w;
	endfunction : seqWord

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dinS1 <= 16'h0000;
			dinS2 <= 16'h0000;
			rybyS1 <= 1'b1;
			rybyS2 <= 1'b1;
		end
		else
		begin
			dinS1 <= flashDin;
			dinS2 <= dinS1;
			rybyS1 <= ready_busy_n; // [R21]
			rybyS2 <= rybyS1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave: always zero wait states
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (apbRd)
			begin
				case (paddr)
					REG_ADDR: prdata <= {13'h0000, progAddr};
					REG_DATA: prdata <= {16'h0000, progData};
					REG_STAT: prdata <= {28'h0000000, rybyS2, fail, done, busy}; // [R22]
					REG_RDAT: prdata <= {16'h0000, rdData};
					REG_CTRL: prdata <= {29'h00000000, op};
					default:
					begin
						prdata <= 32'h00000000;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			progAddr <= 19'h00000;
			progData <= 16'h0000;
		end
		else if (apbWr && !busy)
		begin
			if (paddr == REG_ADDR)
				progAddr <= pwdata[18:0];
			if (paddr == REG_DATA)
				progData <= pwdata[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus cycle sequencer; commands are refused while a sequence is running
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= FS_IDLE;
			op <= 3'h0;
			step <= 3'h0;
			tmr <= 4'h0;
			busy <= 1'b0;
			done <= 1'b0;
			fail <= 1'b0;
			polling <= 1'b0;
			haveLast <= 1'b0;
			lastRead <= 16'h0000;
			rdData <= 16'h0000;
			flashAddr <= 19'h00000;
			flashDout <= 16'h0000;
			flashDoe <= 1'b0;
			chipEn_b <= 1'b1;
			writeEn_b <= 1'b1;
			outEn_b <= 1'b1;
		end
		else
		begin
			case (state)
				FS_IDLE:
				begin
					if (apbWr && paddr == REG_CTRL && !busy)
					begin
						op <= pwdata[2:0];
						step <= 3'h0;
						busy <= 1'b1;
						done <= 1'b0;
						fail <= 1'b0;
						haveLast <= 1'b0;
						polling <= 1'b0;
						state <= (pwdata[2:0] == OP_READ) ? FS_RSET : FS_WSET;
					end
				end
				FS_WSET:
				begin
					{flashAddr, flashDout} <= seqWord(op, step, progAddr, progData);
					flashDoe <= 1'b1;
					chipEn_b <= 1'b0;
					writeEn_b <= 1'b0; // [R08]
					outEn_b <= 1'b1;
					tmr <= STROBE_CNT;
					state <= FS_WLOW;
				end
				FS_WLOW:
				begin
					tmr <= tmr - 4'h1;
					if (tmr == 4'h1)
					begin
						writeEn_b <= 1'b1; // [R08]
						chipEn_b <= 1'b1;
						state <= FS_WHI;
					end
				end
				FS_WHI:
				begin
					flashDoe <= 1'b0;
					step <= step + 3'h1;
					if (op == OP_PROG && step + 3'h1 < SEQ_PROG_LEN)
						state <= FS_WSET; // [R07]
					else if (op == OP_PROG)
					begin
						polling <= 1'b1;
						state <= FS_NEXT;
					end
					else
					begin
						busy <= 1'b0;
						done <= 1'b1;
						state <= FS_IDLE;
					end
				end
				FS_RSET:
				begin
					flashAddr <= progAddr; // [R16]
					chipEn_b <= 1'b0;
					outEn_b <= 1'b0;
					tmr <= STROBE_CNT + 4'h3;
					state <= FS_RLOW;
				end
				FS_RLOW:
				begin
					tmr <= tmr - 4'h1;
					if (tmr == 4'h1)
					begin
						rdData <= dinS2;
						chipEn_b <= 1'b1;
						outEn_b <= 1'b1;
						state <= FS_RHI;
					end
				end
				FS_RHI:
				begin
					haveLast <= 1'b1;
					lastRead <= rdData;
					state <= FS_NEXT;
					if (!polling)
					begin
						busy <= 1'b0;
						done <= 1'b1;
						state <= FS_IDLE;
					end
					else if (haveLast && lastRead[BIT_TOG1] == rdData[BIT_TOG1]
						&& rdData[BIT_POLL] == progData[BIT_POLL]
						&& rdData[BIT_TOG1] == progData[BIT_TOG1])
						polling <= 1'b0; // [R15] [R20]
					else if (haveLast && rdData[BIT_TOUT] && lastRead[BIT_TOUT]
						&& lastRead[BIT_TOG1] != rdData[BIT_TOG1])
					begin
						fail <= 1'b1; // [R14]
						op <= OP_RESET;
						step <= 3'h0;
						polling <= 1'b0;
						state <= FS_WSET; // [R11]
					end
				end
				FS_NEXT:
					state <= FS_RSET;
				default:
					state <= FS_IDLE;
			endcase
		end
	end

	// One strobe must stay low for the full write pulse
	strobeWidth_a: assert property (@(posedge clk) disable iff (!rst_b) // [R08]
		$fell(writeEn_b) |-> !writeEn_b [*4]) else $error("write strobe too short");
	// Four write pulses before polling starts
	progSeq_a: assert property (@(posedge clk) disable iff (!rst_b) // [R07]
		(state == FS_WHI && op == OP_PROG && step == 3'h3) |=> polling) else
		$error("program sequence not four cycles");
	// Data bus driven only while writing
	outEnWrite_a: assert property (@(posedge clk) disable iff (!rst_b) // [R08]
		!outEn_b |-> !flashDoe) else $error("bus contention");
	// Read strobe long enough for the two-stage data synchroniser
	readPulse_a: assert property (@(posedge clk) disable iff (!rst_b) // [R15]
		$fell(outEn_b) |-> !outEn_b [*7]) else $error("read strobe too short");
	// Status polling never issues a write
	pollQuiet_a: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
		polling |-> writeEn_b) else $error("write strobe during polling");
endmodule : fpss_host

// *** fpss_flash_model.sv ***
// Behavioural flash device seen by the host controller
module fpss_flash_model (
	input wire logic [18:0] flashAddr,
	input wire logic [15:0] flashDout,
	input wire logic chipEn_b,
	input wire logic writeEn_b,
	input wire logic outEn_b,
	input wire logic failNext,
	input wire logic eraseNow,
	output logic [15:0] devData,
	output logic devDrive,
	output logic rbLow
);
	timeunit 1ns;
	timeprecision 1ps;
	parameter int PROG_NS = 1000;
	parameter int SUSP_NS = 1500;
	logic [15:0] mem [0:15];
	logic [18:0] latA;
	logic [15:0] progD;
	logic [1:0] step;
	logic setup, busy, fail, tog;
	logic erasing, suspended, suspReq;
	wire strobe = writeEn_b | chipEn_b;
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
		step = 2'h0;
		{setup, busy, fail, tog, erasing, suspended, suspReq} = 7'h00;
	end
	// Sampled just after the fall so the address has settled
	always @(negedge strobe) #1 latA = flashAddr;
	always @(posedge strobe)
	begin
		if (busy)
		begin
			// Only a reset after a timeout gets through while busy
			if (fail && flashDout[7:0] == 8'hf0) {busy, fail} = 2'b00;
		end
		else if (erasing)
		begin
			// Only suspend is heard while erasing
			if (flashDout[7:0] == 8'hb0) suspReq = 1'b1;
		end
		else if (suspended && flashDout[7:0] == 8'h30) {suspended, erasing} = 2'b01;
		else if (setup)
		begin
			setup = 1'b0;
			progD = flashDout;
			fail = failNext;
			busy = 1'b1;
			mem[latA[3:0]] = mem[latA[3:0]] & flashDout;
		end
		else if (flashDout[7:0] == 8'hf0) step = 2'h0;
		else if (step == 2'h0) step = (latA[10:0] == 11'h555 && flashDout[7:0] == 8'haa) ? 2'h1 : 2'h0;
		else if (step == 2'h1) step = (latA[10:0] == 11'h2aa && flashDout[7:0] == 8'h55) ? 2'h2 : 2'h0;
		else
		begin
			setup = flashDout[7:0] == 8'ha0;
			step = 2'h0;
		end
	end
	// Self-timed; a failed run stays busy until reset
	always @(posedge busy) #PROG_NS if (!fail) busy = 1'b0;
	// Suspend lands after a latency well inside the erase limit
	always @(posedge suspReq)
	begin
		#SUSP_NS;
		if (erasing) {erasing, suspended} = 2'b01;
		suspReq = 1'b0;
	end
	always @(posedge eraseNow) if (!busy) erasing = 1'b1;
	always @(negedge eraseNow) {erasing, suspended} = 2'b00;
	always @(negedge outEn_b) if (busy || erasing) tog = ~tog;
	assign devDrive = !outEn_b && !chipEn_b;
	assign devData = busy ? {8'h00, ~progD[7], tog, fail, 5'h00} :
		erasing ? {8'h00, 1'b0, tog, 1'b0, 1'b0, 1'b1, tog, 2'h0} :
		mem[flashAddr[3:0]];
	assign rbLow = busy || erasing;
endmodule : fpss_flash_model

// *** fpss_host_test.sv ***
// Self-checking bench for the flash host controller
module fpss_host_test;
	timeunit 1ns;
	timeprecision 1ps;
	import fpss_pkg::*;
	`define CHK(a, b) begin checked++; if ((a) !== (b)) begin numErrors++; \
		$display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
	logic clk, rst_b, psel, penable, pwrite, pready, pslverr, flashDoe, ceb, web, oeb;
	logic rb, failNext, eraseNow, devDrive, rbLow, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [18:0] fa;
	logic [15:0] fdo, devData, lastDin;
	wire [15:0] fdi = devDrive ? devData : flashDoe ? fdo : ~lastDin;
	int numErrors = 0, checked = 0, cyc = 0;
	fpss_host i_fpss_host (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flashAddr(fa), .flashDout(fdo), .flashDoe(flashDoe),
		.flashDin(fdi), .chipEn_b(ceb), .writeEn_b(web), .outEn_b(oeb), .ready_busy_n(rb));
	fpss_flash_model i_fpss_flash_model (.flashAddr(fa), .flashDout(fdo), .chipEn_b(ceb),
		.writeEn_b(web), .outEn_b(oeb), .failNext(failNext), .devData(devData),
		.devDrive(devDrive), .rbLow(rbLow), .eraseNow(eraseNow));
	assign rb = rbLow ? 1'b0 : 1'b1; // Pull-up on the shared line
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		lastDin <= fdi;
		cyc++;
		if (cyc == 60000)
		begin
			numErrors++;
			stop_test();
		end
	end
	task stop_test;
		$display("checked %0d errors %0d", checked, numErrors);
		if (numErrors == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : stop_test
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task prog(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, REG_ADDR, {24'h0, a});
		apb(1'b1, REG_DATA, {16'h0, d});
		apb(1'b1, REG_CTRL, {29'h0, OP_PROG});
	endtask : prog
	task wait_idle;
		do apb(1'b0, REG_STAT, 32'h0); while (rd[ST_BUSY] !== 1'b0);
	endtask : wait_idle
	task read_word(input logic [7:0] a, input logic [15:0] exp);
		apb(1'b1, REG_ADDR, {24'h0, a});
		apb(1'b1, REG_CTRL, {29'h0, OP_READ});
		wait_idle();
		apb(1'b0, REG_RDAT, 32'h0);
		`CHK(rd[15:0], exp)
	endtask : read_word
	////////////////////////////////////////////////////////////////////////////////
	task t_idle;
		apb(1'b0, REG_STAT, 32'h0);
		`CHK(rd[3:0], 4'h8)
		apb(1'b0, 8'h20, 32'h0);
		`CHK(err, 1'b1)
		$display("test idle done");
	endtask : t_idle
	task t_prog;
		prog(8'h05, 16'h1234);
		repeat (30) @(posedge clk);
		apb(1'b0, REG_STAT, 32'h0);
		`CHK(rd[3:0], 4'h1)
		apb(1'b1, REG_ADDR, 32'h9); // Refused while busy
		apb(1'b0, REG_ADDR, 32'h0);
		`CHK(rd[18:0], 19'h00005)
		wait_idle();
		`CHK(rd[2:1], 2'b01)
		read_word(8'h05, 16'h1234);
		$display("test prog done");
	endtask : t_prog
	task t_zero;
		prog(8'h05, 16'h5634);
		wait_idle();
		read_word(8'h05, 16'h1234);
		$display("test zero done");
	endtask : t_zero
	task t_fail;
		failNext <= 1'b1;
		prog(8'h07, 16'h0011);
		wait_idle();
		`CHK(rd[ST_FAIL], 1'b1)
		failNext <= 1'b0;
		prog(8'h07, 16'h0011);
		wait_idle();
		`CHK(rd[2:1], 2'b01)
		read_word(8'h07, 16'h0011);
		$display("test fail done");
	endtask : t_fail
	task t_susp;
		apb(1'b1, REG_CTRL, {29'h0, OP_SUSP}); // Idle device ignores both
		wait_idle();
		apb(1'b1, REG_CTRL, {29'h0, OP_RESUME});
		wait_idle();
		`CHK(rd[3], 1'b1)
		read_word(8'h05, 16'h1234);
		eraseNow <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b0, REG_STAT, 32'h0);
		`CHK(rd[3], 1'b0)
		repeat (2)
		begin
			apb(1'b1, REG_CTRL, {29'h0, OP_SUSP});
			wait_idle();
			repeat (80) @(posedge clk);
			apb(1'b0, REG_STAT, 32'h0);
			`CHK(rd[3], 1'b1)
			read_word(8'h05, 16'h1234);
			apb(1'b1, REG_CTRL, {29'h0, OP_RESUME});
			wait_idle();
			repeat (4) @(posedge clk);
			apb(1'b0, REG_STAT, 32'h0);
			`CHK(rd[3], 1'b0)
		end
		eraseNow <= 1'b0;
		repeat (4) @(posedge clk);
		$display("test susp done");
	endtask : t_susp
	initial
	begin
		{rst_b, psel, penable, pwrite, failNext, eraseNow} = 6'h00;
		paddr = 8'h0;
		pwdata = 32'h0;
		lastDin = 16'h0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		t_idle();
		t_prog();
		t_zero();
		t_fail();
		t_susp();
		stop_test();
	end
endmodule : fpss_host_test
